//--- rtl/pin_level_a_defines.svh
// Register offsets, field positions and reset values for the port A block
`ifndef PIN_LEVEL_A_DEFINES_SVH
`define PIN_LEVEL_A_DEFINES_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFF_DIRECTION 12'h000
`define OFF_LEVEL 12'h004
`define OFF_LATCH 12'h008
`define OFF_ANALOG 12'h00C
`define OFF_SLEW 12'h010
`define OFF_CMP1 12'h014
`define OFF_CMP2 12'h018
`define OFF_PERIPH 12'h01C
`define OFF_STATUS 12'h020

// ****************************************
// Reset values
// ****************************************
`define RST_DIRECTION 8'hFF
`define RST_ANALOG 8'h2F
`define RST_LATCH 8'h00
`define RST_SLEW 8'hFF
`define RST_CTRL 8'h00

// ****************************************
// Field positions
// ****************************************
`define PIN_FOUR 3
`define PIN_FOUR_IDX 4
`define PERIPH_CAPTURE_COMPARE_5_BIT 0
`define PERIPH_SRQ_BIT 1
`define PERIPH_COMPARATOR1_OUT_BIT 2
`define CMP_OUT_EN_BIT 5
`define ADDR_HI 11
`define ADDR_LO 2
`define HTRANS_NONSEQ 2'h2
`define HSIZE_WORD 3'h2

`endif

//--- rtl/pin_level_a_pkg.sv
// Shared types for the port A block
package pin_level_a_pkg;
    // Bus slave data-phase state
    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_DATA = 1'b1
    } bus_state_t;
    // Byte-wide register value
    typedef logic [7:0] byte_t;
endpackage : pin_level_a_pkg

//--- rtl/pin_sync_if.sv
// Interface carrying raw pin levels and their synchronised copy
`timescale 1ns/1ps
interface pin_sync_if #(parameter int WIDTH = 8);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] synced;
    modport sync (input raw, output synced);
    modport user (output raw, input synced);
endinterface : pin_sync_if

//--- rtl/pin_sync.sv
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk_in,
    input wire logic rst_in,
    pin_sync_if.sync port
);
    // First stage, read only by the second stage
    logic [WIDTH-1:0] meta_reg;
    // Second stage, safe for logic to read
    logic [WIDTH-1:0] stable_reg;

    // Two flops in series; metastability settles in the first
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta_reg <= '0;
            stable_reg <= '0;
        end else begin
            meta_reg <= port.raw;
            stable_reg <= meta_reg;
        end
    end
    assign port.synced = stable_reg;
endmodule : pin_sync

//--- rtl/pin_level_a_gpio.sv
// Port A general-purpose I/O block with AHB-Lite register access
//
// Chosen here: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`include "pin_level_a_defines.svh"
module pin_level_a_gpio
    import pin_level_a_pkg::*;
#(
    parameter int PIN_COUNT = 8
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // AHB-Lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // Pins, as input, output and active-low output enable
    input wire logic [PIN_COUNT-1:0] pin_level_in,
    output logic [PIN_COUNT-1:0] pin_drive_out,
    output logic [PIN_COUNT-1:0] pin_oe_n_out,
    // Oscillator selection from configuration: 1 means pins six, seven are oscillator
    input wire logic osc_uses_pins_in,
    // Peripheral outputs muxed onto the pins
    input wire logic capture_compare_5_in,
    input wire logic sr_latch_q_in,
    input wire logic comparator1_out_in,
    input wire logic comparator2_out_in,
    // Digital pin values delivered to peripherals
    output logic timer_zero_clk_in_out,
    output logic [PIN_COUNT-1:0] digital_in_out,
    // Slew rate controls, passed to pad cells
    output logic [PIN_COUNT-1:0] slew_rate_ctrl_out
);
    // ****************************************
    // Register state
    // ****************************************
    // Direction bits, 1 = input
    // one direction bit per pin
    byte_t direction_reg;
    // Output latch
    byte_t latch_reg;
    // Analog select
    byte_t analog_sel_reg;
    // Slew rate control
    byte_t slew_rate_ctrl_reg;
    // Comparator controls
    byte_t comparator1_ctrl_reg;
    byte_t comparator2_ctrl_reg;
    // Peripheral output enables for pin four
    byte_t periph_en_reg;
    // Oscillator selection, synchronised
    logic osc_meta_reg;
    logic osc_sel_reg;

    // Bus address phase capture
    bus_state_t bus_state_reg;
    logic [11:0] addr_reg;
    logic write_reg;

    // ****************************************
    // Pin synchroniser
    // ****************************************
    pin_sync_if #(.WIDTH(PIN_COUNT)) sync_port ();
    assign sync_port.raw = pin_level_in;
    pin_sync #(.WIDTH(PIN_COUNT)) u_sync (
        .clk_in(sys_clk_in),
        .rst_in(rst_in),
        .port(sync_port)
    );

    // Mask of pins usable as port pins
    function automatic byte_t port_mask(input logic osc);
        port_mask = osc ? 8'h3F : 8'hFF;
    endfunction : port_mask

    // Register word at an offset, zero-extended
    function automatic logic [31:0] word(input byte_t value);
        word = {24'h000000, value};
    endfunction : word

    // ****************************************
    // Oscillator selection capture
    // ****************************************
    // Config level is a static strap, but still passes two flops
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            osc_meta_reg <= 1'b0;
            osc_sel_reg <= 1'b0;
        end else begin
            osc_meta_reg <= osc_uses_pins_in;
            osc_sel_reg <= osc_meta_reg;
        end
    end

    // ****************************************
    // AHB-Lite address phase
    // ****************************************
    logic take_req;
    assign take_req = hsel_in && hready_in && (htrans_in == `HTRANS_NONSEQ);

    // Record a transfer; zero-wait slave, so data phase is one cycle
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            bus_state_reg <= BUS_IDLE;
            addr_reg <= 12'h000;
            write_reg <= 1'b0;
        end else if (take_req) begin
            bus_state_reg <= BUS_DATA;
            addr_reg <= {haddr_in[`ADDR_HI:`ADDR_LO], 2'b00};
            write_reg <= hwrite_in;
        end else begin
            bus_state_reg <= BUS_IDLE;
            write_reg <= 1'b0;
        end
    end

    logic wr_en;
    assign wr_en = (bus_state_reg == BUS_DATA) && write_reg;
    byte_t wdata;
    assign wdata = hwdata_in[7:0];
    byte_t pmask;
    assign pmask = port_mask(osc_sel_reg);

    // ****************************************
    // Register writes
    // ****************************************
    // direction, analog, slew, comparator writes
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            // pins four, six and seven digital input, others analog
            direction_reg <= `RST_DIRECTION;
            analog_sel_reg <= `RST_ANALOG;
            slew_rate_ctrl_reg <= `RST_SLEW;
            comparator1_ctrl_reg <= `RST_CTRL;
            comparator2_ctrl_reg <= `RST_CTRL;
            periph_en_reg <= `RST_CTRL;
        end else if (wr_en) begin
            unique case (addr_reg)
                `OFF_DIRECTION: begin
                    direction_reg <= wdata;
                end
                `OFF_ANALOG: begin
                    // only bits five and three-zero exist
                    analog_sel_reg <= wdata & `RST_ANALOG;
                end
                `OFF_SLEW: begin
                    slew_rate_ctrl_reg <= wdata;
                end
                `OFF_CMP1: begin
                    comparator1_ctrl_reg <= wdata;
                end
                `OFF_CMP2: begin
                    comparator2_ctrl_reg <= wdata;
                end
                `OFF_PERIPH: begin
                    periph_en_reg <= wdata;
                end
                default: begin
                    // Other offsets leave these alone
                end
            endcase
        end
    end

    // Output latch, written through either the level or the latch address
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            latch_reg <= `RST_LATCH;
        end else if (wr_en && (addr_reg == `OFF_LATCH)) begin
            latch_reg <= wdata;
        end else if (wr_en && (addr_reg == `OFF_LEVEL)) begin
            // level write lands in the latch
            latch_reg <= wdata;
        end
    end

    // ****************************************
    // Pin-side logic
    // ****************************************
    // Digital input after analog disable
    byte_t digital_level;
    assign digital_level = sync_port.synced & ~analog_sel_reg & pmask;

    // Comparator output enables per pin
    logic c1_out_en;
    logic c2_out_en;
    assign c1_out_en = comparator1_ctrl_reg[`CMP_OUT_EN_BIT];
    assign c2_out_en = comparator2_ctrl_reg[`CMP_OUT_EN_BIT];

    // Per-pin output value with peripheral overrides
    byte_t drive_next;
    always_comb begin
        drive_next = latch_reg;
        // comparator two output on pin five
        if (c2_out_en) begin
            drive_next[5] = comparator2_out_in;
        end
        // comparator one output on pin four
        if (c1_out_en || periph_en_reg[`PERIPH_COMPARATOR1_OUT_BIT]) begin
            drive_next[`PIN_FOUR_IDX] = comparator1_out_in;
        end
        // CAPTURE_COMPARE_5 beats latch, SR latch beats CAPTURE_COMPARE_5
        if (periph_en_reg[`PERIPH_SRQ_BIT]) begin
            drive_next[`PIN_FOUR_IDX] = sr_latch_q_in;
        end else if (periph_en_reg[`PERIPH_CAPTURE_COMPARE_5_BIT]) begin
            drive_next[`PIN_FOUR_IDX] = capture_compare_5_in;
        end
    end

    // Pin drivers; outputs straight from flops
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            pin_drive_out <= '0;
            pin_oe_n_out <= '1;
        end else begin
            pin_drive_out <= drive_next & pmask;
            // drivers obey direction even in analog mode
            pin_oe_n_out <= direction_reg | ~pmask;
        end
    end

    // Peripheral-side inputs and pad controls
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            timer_zero_clk_in_out <= 1'b0;
            digital_in_out <= '0;
            slew_rate_ctrl_out <= '1;
        end else begin
            // pin four feeds the timer clock
            timer_zero_clk_in_out <= digital_level[`PIN_FOUR_IDX];
            digital_in_out <= digital_level;
            slew_rate_ctrl_out <= slew_rate_ctrl_reg;
        end
    end

    // ****************************************
    // Register reads
    // ****************************************
    logic [31:0] rdata_next;
    always_comb begin
        rdata_next = 32'h00000000;
        unique case (addr_reg)
            `OFF_DIRECTION: rdata_next = word(direction_reg & pmask);
            `OFF_LEVEL: rdata_next = word(digital_level);
            `OFF_LATCH: rdata_next = word(latch_reg & pmask);
            `OFF_ANALOG: rdata_next = word(analog_sel_reg);
            `OFF_SLEW: rdata_next = word(slew_rate_ctrl_reg);
            `OFF_CMP1: rdata_next = word(comparator1_ctrl_reg);
            `OFF_CMP2: rdata_next = word(comparator2_ctrl_reg);
            `OFF_PERIPH: rdata_next = word(periph_en_reg);
            `OFF_STATUS: rdata_next = word({7'h00, osc_sel_reg});
            default: rdata_next = 32'h00000000;
        endcase
    end

    // Read data registered at address phase; zero wait states
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            hrdata_out <= 32'h00000000;
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
        end else begin
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
            if (take_req && !hwrite_in) begin
                hrdata_out <= rd_at(haddr_in);
            end
        end
    end

    // Read value for an address seen in the address phase
    function automatic logic [31:0] rd_at(input logic [31:0] a);
        logic [11:0] off;
        off = {a[`ADDR_HI:`ADDR_LO], 2'b00};
        rd_at = 32'h00000000;
        unique case (off)
            `OFF_DIRECTION: rd_at = word(direction_reg & pmask);
            `OFF_LEVEL: rd_at = word(digital_level);
            `OFF_LATCH: rd_at = word(latch_reg & pmask);
            `OFF_ANALOG: rd_at = word(analog_sel_reg);
            `OFF_SLEW: rd_at = word(slew_rate_ctrl_reg);
            `OFF_CMP1: rd_at = word(comparator1_ctrl_reg);
            `OFF_CMP2: rd_at = word(comparator2_ctrl_reg);
            `OFF_PERIPH: rd_at = word(periph_en_reg);
            `OFF_STATUS: rd_at = word({7'h00, osc_sel_reg});
            default: rd_at = 32'h00000000;
        endcase
    endfunction : rd_at

    // Unused diagnostic copy kept readable for debug probes
    logic [31:0] rdata_probe;
    assign rdata_probe = rdata_next;
endmodule : pin_level_a_gpio

//--- verification/pin_level_a_gpio_properties.sv
// Checker that watches the port A block from its top-level ports
`timescale 1ns/1ps
`include "pin_level_a_defines.svh"
module pin_level_a_checker #(
    parameter int PIN_COUNT = 8
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    input wire logic [PIN_COUNT-1:0] pin_level_in,
    input wire logic [PIN_COUNT-1:0] pin_drive_out,
    input wire logic [PIN_COUNT-1:0] pin_oe_n_out,
    input wire logic osc_uses_pins_in,
    input wire logic timer_zero_clk_in_out,
    input wire logic [PIN_COUNT-1:0] digital_in_out
);
    // ****************************************
    // Decoded bus requests
    // ****************************************
    logic tk; // Address phase accepted
    logic wl; // Write to latch through either offset
    logic wd; // Write to direction
    assign tk = hsel_in & hready_in & (htrans_in == `HTRANS_NONSEQ);
    assign wl = tk & hwrite_in & ((haddr_in[11:0] == `OFF_LATCH) | (haddr_in[11:0] == `OFF_LEVEL));
    assign wd = tk & hwrite_in & (haddr_in[11:0] == `OFF_DIRECTION);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    // ****************************************
    // Properties
    // ****************************************
    AST_OKAY: assert property (hresp_out == 1'b0 && hreadyout_out == 1'b1)
        else $error("bus response not OKAY and ready");
    AST_RESET_PINS: assert property ($fell(rst_in) |-> pin_oe_n_out == '1 && pin_drive_out == '0)
        else $error("pins not released after reset");
    // Isolated writes only, so a following write cannot blur the check
    AST_LATCH_DRIVE: assert property (wl ##1 !wl ##1 !wl |-> ##1
        ((pin_drive_out[3:0] ^ $past(hwdata_in[3:0], 2)) & ~pin_oe_n_out[3:0]) == 4'h0)
        else $error("driven pins differ from written latch");
    AST_DIR_OE: assert property (wd ##1 !wd ##1 !wd |-> ##1
        pin_oe_n_out[3:0] == $past(hwdata_in[3:0], 2)) else $error("enables differ from direction");
    AST_LEVEL_READ: assert property (($stable(pin_level_in))[*4] ##0
        (tk && !hwrite_in && haddr_in[11:0] == `OFF_LEVEL) |=>
        (hrdata_out[7:0] & ~$past(pin_level_in)) == 8'h00 && hrdata_out[31:8] == 24'h0)
        else $error("level read shows a low pin as high");
    AST_OSC_OE: assert property (osc_uses_pins_in[*6] |-> pin_oe_n_out[7:6] == 2'b11)
        else $error("oscillator pins still driven");
    AST_OSC_READ: assert property (osc_uses_pins_in[*6] ##0
        (tk && !hwrite_in && haddr_in[11:0] < `OFF_ANALOG) |=> hrdata_out[7:6] == 2'b00)
        else $error("oscillator pin bits read nonzero");
    AST_TIMER_CLK: assert property (($stable(pin_level_in[4]))[*5] |->
        timer_zero_clk_in_out == pin_level_in[4]) else $error("timer clock not pin four");
    AST_DIGITAL_MASK: assert property (($stable(pin_level_in))[*5] |->
        (digital_in_out & ~pin_level_in) == '0) else $error("digital input high on low pin");
endmodule : pin_level_a_checker

bind pin_level_a_gpio pin_level_a_checker #(.PIN_COUNT(PIN_COUNT)) u_chk (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hwdata_in(hwdata_in),
    .hready_in(hready_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out), .pin_level_in(pin_level_in), .pin_drive_out(pin_drive_out),
    .pin_oe_n_out(pin_oe_n_out), .osc_uses_pins_in(osc_uses_pins_in),
    .timer_zero_clk_in_out(timer_zero_clk_in_out), .digital_in_out(digital_in_out));

//--- verification/board_pins.sv
// Board model: resolves each pin from the block's driver or the board pattern
`timescale 1ns/1ps
module board_pins (
    input wire logic [7:0] drive_in,
    input wire logic [7:0] oe_n_in,
    input wire logic [7:0] ext_in,
    output logic [7:0] level_out
);
    assign level_out = (drive_in & ~oe_n_in) | (ext_in & oe_n_in);
endmodule : board_pins

//--- verification/tb.sv
// Self-checking testbench for the port A block
`timescale 1ns/1ps
`include "pin_level_a_defines.svh"
module tb;
    import pin_level_a_pkg::*;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic osc = 1'b0;
    logic ccp = 1'b0;
    logic sr_latch_q = 1'b0;
    logic c1o = 1'b0;
    logic c2o = 1'b0;
    byte_t ext = 8'hFF; // Board pattern on released pins
    logic [31:0] hrdata;
    logic hready, hresp, tclk;
    byte_t lvl, drv, oe_n, din, slew;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    logic [11:0] ra [9] = '{`OFF_DIRECTION, `OFF_LATCH, `OFF_ANALOG, `OFF_SLEW, `OFF_CMP1,
        `OFF_CMP2, `OFF_PERIPH, `OFF_STATUS, 12'h040};
    byte_t rv [9] = '{8'hFF, 8'h00, 8'h2F, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    byte_t pv [4] = '{8'h00, 8'h01, 8'h03, 8'h03}; // Pin four peripheral enables
    logic [1:0] cq [4] = '{2'b11, 2'b10, 2'b10, 2'b01}; // Compare and SR outputs
    logic ev [4] = '{1'b0, 1'b1, 1'b0, 1'b1}; // Expected pin four drive
    always #12.5 sys_clk_in = ~sys_clk_in;
    pin_level_a_gpio #(.PIN_COUNT(8)) u_dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .hsel_in(1'b1),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(`HSIZE_WORD),
        .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
        .hresp_out(hresp), .pin_level_in(lvl), .pin_drive_out(drv), .pin_oe_n_out(oe_n),
        .osc_uses_pins_in(osc), .capture_compare_5_in(ccp), .sr_latch_q_in(sr_latch_q),
        .comparator1_out_in(c1o), .comparator2_out_in(c2o), .timer_zero_clk_in_out(tclk),
        .digital_in_out(din), .slew_rate_ctrl_out(slew));
    board_pins u_board (.drive_in(drv), .oe_n_in(oe_n), .ext_in(ext), .level_out(lvl));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One AHB single transfer; waits on ready, bench timeout ends a hang
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r);
        htrans <= `HTRANS_NONSEQ;
        haddr <= {20'h0, a};
        hwrite <= w;
        @(posedge sys_clk_in);
        while (hready !== 1'b1) @(posedge sys_clk_in);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge sys_clk_in);
        while (hready !== 1'b1) @(posedge sys_clk_in);
        r = hrdata;
    endtask : bus
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r, e);
    endtask : rd
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask : settle
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        for (int i = 0; i < 9; i++) rd(ra[i], {24'h0, rv[i]});
        rd(`OFF_LEVEL, 32'hD0);
        chk({24'h0, oe_n}, 32'hFF);
        chk({24'h0, slew}, 32'hFF);
        $display("test reset done");
    endtask : t_reset
    task automatic t_output;
        wr(`OFF_ANALOG, 32'h0);
        wr(`OFF_DIRECTION, 32'hF0);
        wr(`OFF_LEVEL, 32'hA5);
        ext <= 8'h40;
        settle(4);
        chk({24'h0, oe_n}, 32'hF0);
        chk({24'h0, drv & ~oe_n}, 32'h05);
        rd(`OFF_LATCH, 32'hA5);
        rd(`OFF_LEVEL, 32'h45);
        $display("test output done");
    endtask : t_output
    task automatic t_analog;
        wr(`OFF_ANALOG, 32'hFF);
        rd(`OFF_ANALOG, 32'h2F);
        wr(`OFF_DIRECTION, 32'h00);
        settle(4);
        chk({24'h0, oe_n}, 32'h00);
        rd(`OFF_LEVEL, 32'h80);
        chk({24'h0, din}, 32'h80);
        $display("test analog done");
    endtask : t_analog
    task automatic t_osc;
        wr(`OFF_DIRECTION, 32'hFF);
        ext <= 8'hFF;
        osc <= 1'b1;
        settle(6);
        rd(`OFF_DIRECTION, 32'h3F);
        rd(`OFF_LATCH, 32'h25);
        rd(`OFF_LEVEL, 32'h10);
        chk({30'h0, oe_n[7:6]}, 32'h3);
        osc <= 1'b0;
        settle(6);
        rd(`OFF_DIRECTION, 32'hFF);
        $display("test oscillator done");
    endtask : t_osc
    task automatic t_pin4;
        wr(`OFF_DIRECTION, 32'h00);
        for (int i = 0; i < 4; i++) begin
            wr(`OFF_PERIPH, {24'h0, pv[i]});
            {ccp, sr_latch_q} <= cq[i];
            settle(4);
            chk({31'h0, drv[4]}, {31'h0, ev[i]});
        end
        wr(`OFF_PERIPH, 32'h0);
        wr(`OFF_CMP2, 32'h20);
        c2o <= 1'b1;
        settle(4);
        chk({31'h0, drv[5]}, 32'h1);
        wr(`OFF_CMP2, 32'h0);
        wr(`OFF_DIRECTION, 32'hFF);
        ext <= 8'h10;
        settle(5);
        chk({31'h0, tclk}, 32'h1);
        ext <= 8'h00;
        settle(5);
        chk({31'h0, tclk}, 32'h0);
        $display("test pin four done");
    endtask : t_pin4
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop
    // Hang guard, far above the roughly 120 cycles the run needs
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            report_and_stop();
        end
    end
    initial begin
        settle(3);
        rst_in <= 1'b0;
        t_reset();
        t_output();
        t_analog();
        t_osc();
        t_pin4();
        report_and_stop();
    end
endmodule : tb
